/* hdl/wdg_watchdog.sv */
// Windowed SPI watchdog core with link-domain command capture
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Refresh ok only after A and B in window
// - Missed or misplaced service raises window error
// - Qualified window error latches readable reset flag
// - Test-mode flag shows machine in test state
// - Unexpected error reaching retry threshold latches lockout, disabling arming
// - Test command: run to test, initial to override when disable pin set
// - Lockout only once retry count reaches threshold
// - Threshold writes locked after run entered
// - Fast mode 8 us steps, 2 ms span
// - Slow mode 64 us steps, 16.3 ms span
// - Timer config accepted only in init state
// - Override bit allows unlimited initial state
// - Early or late correct key raises error
// - Wrong key never raises window error
// - Both codes in window restart the window
// - Service read returns present timer count
// - Reset pulse output; fault flags kept
// - Disable pin level reported in status word
// - Disable pin stops timer, no faults
// - Error enters reset state for 1 ms
// - Initial state disables arming, needs a service key within 500 ms
// - Test state inhibits deployment
// - Machine reset returns initial, outputs inactive
module wdg_watchdog import wdg_pkg::*; #(
	parameter int RST_STATE_CYCLES = RST_STATE_CYC,
	parameter int INIT_DEADLINE_CYCLES = INIT_DEADLINE_CYC
) (
	// Clocks and resets
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic machineReset,
	// Host command in link domain
	input wire wdg_cmd_t linkCmd,
	// Operating state and pins
	input wire logic initOpState,
	input wire logic disablePin,
	// Outputs
	output wdg_stat_t status,
	output logic refreshOk,
	output logic windowError,
	output logic wdResetOut,
	output logic armEnable,
	output logic deployInhibit
);
	// Link side: capture command words and toggle an event bit
	wdg_cmd_t linkHold;
	logic linkTog;
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			linkHold <= '0;
			linkTog <= 1'b0;
		end else if (linkCmd.serviceWr | linkCmd.testEntry | linkCmd.overrideSet | linkCmd.cfgWr | linkCmd.thWr) begin
			linkHold <= linkCmd;
			linkTog <= ~linkTog;
		end
	end

	// Toggle crosses by two flip-flops, data is stable by then
	logic togS1, togS2, togS3;
	logic pinS1, pinS2;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			togS1 <= 1'b0;
			togS2 <= 1'b0;
			togS3 <= 1'b0;
			pinS1 <= 1'b0;
			pinS2 <= 1'b0;
		end else begin
			togS1 <= linkTog;
			togS2 <= togS1;
			togS3 <= togS2;
			pinS1 <= disablePin;
			pinS2 <= pinS1;
		end
	end
	wire cmdEvt = togS2 ^ togS3;
	wdg_cmd_t cmdQ;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cmdQ <= '0;
		else if (cmdEvt)
			cmdQ <= linkHold;
	end
	logic evtQ;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			evtQ <= 1'b0;
		else
			evtQ <= cmdEvt;
	end
	wire svcWr = evtQ & cmdQ.serviceWr;
	wire tstCmd = evtQ & cmdQ.testEntry;
	wire ovrCmd = evtQ & cmdQ.overrideSet;
	wire cfgCmd = evtQ & cmdQ.cfgWr;
	wire thCmd = evtQ & cmdQ.thWr;
	wire disabled = pinS2;

	wdg_state_t state, next_state;
	logic slowMode;
	logic [7:0] winMin, winDelta, timer;
	logic [3:0] retryTh, retryCnt;
	logic cfgFrozen, thLock, ovrBit, gotA, gotB, resetFlag, lockout;
	logic [12:0] prescale;
	logic [31:0] stateCnt;
	logic [11:0] pulseCnt;

	wire inRun = (state == ST_RUN) | (state == ST_TEST);
	wire inInit = state == ST_INITIAL;
	wire [12:0] stepCyc = slowMode ? 13'(SLOW_STEP_CYC) : 13'(FAST_STEP_CYC);
	wire [11:0] maxTicks = slowMode ? 12'(SLOW_MAX_TICKS) : 12'(FAST_MAX_TICKS);
	wire tick = prescale == stepCyc - 13'd1;
	wire [8:0] winEnd = {1'b0, winMin} + {1'b0, winDelta};
	wire inWindow = ({1'b0, timer} >= {1'b0, winMin}) & ({1'b0, timer} < winEnd);
	wire goodKey = svcWr & ((cmdQ.serviceCode == CODE_A) | (cmdQ.serviceCode == CODE_B));
	wire keyA = goodKey & (cmdQ.serviceCode == CODE_A);
	wire keyB = goodKey & (cmdQ.serviceCode == CODE_B);
	wire completes = (keyA & gotB) | (keyB & gotA);
	wire earlyLate = goodKey & ~inWindow;
	wire expired = tick & ({1'b0, timer} + 9'd1 >= winEnd) | ({4'h0, timer} >= maxTicks);
	wire initTimeout = inInit & ~ovrBit & ~gotA & ~gotB & (stateCnt >= 32'(INIT_DEADLINE_CYCLES));
	wire runErr = inRun & ~disabled & (earlyLate | expired);
	wire anyErr = (runErr | (initTimeout & ~disabled));
	wire okEvt = inRun & ~disabled & completes & inWindow;
	wire reachTh = retryCnt + 4'd1 >= retryTh;
	wire rstDone = (state == ST_RESET) & (stateCnt >= 32'(RST_STATE_CYCLES) - 32'd1);

	// Machine transitions
	always_comb begin
		next_state = state;
		unique case (state)
			ST_INITIAL: begin
				if (anyErr)
					next_state = ST_RESET;
				else if (tstCmd & disabled)
					next_state = ST_OVERRIDE;
				else if (okEvt | (goodKey & ~disabled & ~initOpState))
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (anyErr)
					next_state = ST_RESET;
				else if (tstCmd)
					next_state = ST_TEST;
			end
			ST_TEST: begin
				if (anyErr)
					next_state = ST_RESET;
				else if (okEvt)
					next_state = ST_RUN;
			end
			ST_RESET: begin
				if (rstDone)
					next_state = ST_INITIAL;
			end
			ST_OVERRIDE: next_state = ST_OVERRIDE;
			default: next_state = ST_INITIAL;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			state <= ST_INITIAL;
		else if (machineReset)
			state <= ST_INITIAL;
		else
			state <= next_state;
	end

	// Configuration, frozen once the init operating state is left
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slowMode <= 1'b0;
			winMin <= WIN_MIN_RST;
			winDelta <= WIN_DELTA_RST;
			cfgFrozen <= 1'b0;
		end else begin
			if (!initOpState)
				cfgFrozen <= 1'b1;
			if (cfgCmd & initOpState & ~cfgFrozen) begin
				slowMode <= cmdQ.slowMode;
				winMin <= cmdQ.windowMin;
				winDelta <= cmdQ.windowDelta;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			retryTh <= RETRY_TH_RST;
			thLock <= 1'b0;
			ovrBit <= 1'b0;
		end else begin
			if (machineReset)
				thLock <= 1'b0;
			else if (state == ST_RUN)
				thLock <= 1'b1;
			if (thCmd & ~thLock & ~(state == ST_RUN))
				retryTh <= cmdQ.retryThreshold;
			if (machineReset)
				ovrBit <= 1'b0;
			else if (ovrCmd)
				ovrBit <= 1'b1;
		end
	end

	// Window timer, prescaler and state timer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= '0;
			timer <= TIMER_RST;
			stateCnt <= '0;
			gotA <= 1'b0;
			gotB <= 1'b0;
		end else begin
			stateCnt <= (next_state != state | machineReset | ovrBit & inInit) ? 32'd0 : stateCnt + 32'd1;
			if (disabled | ~inRun | okEvt | machineReset) begin
				prescale <= '0;
				timer <= TIMER_RST;
			end else if (tick) begin
				prescale <= '0;
				timer <= timer + 8'd1;
			end else
				prescale <= prescale + 13'd1;
			if (okEvt | anyErr | machineReset | disabled) begin
				gotA <= 1'b0;
				gotB <= 1'b0;
			end else begin
				if (keyA)
					gotA <= 1'b1;
				if (keyB)
					gotB <= 1'b1;
			end
		end
	end

	// Fault flags and retry counter, preserved across the reset state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resetFlag <= 1'b0;
			lockout <= 1'b0;
			retryCnt <= '0;
		end else if (machineReset) begin
			resetFlag <= 1'b0;
			lockout <= 1'b0;
			retryCnt <= '0;
		end else if (anyErr & ~(state == ST_RESET)) begin
			resetFlag <= 1'b1;
			if (state != ST_TEST) begin
				retryCnt <= (retryCnt == 4'hF) ? retryCnt : retryCnt + 4'd1;
				if (reachTh)
					lockout <= 1'b1;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
			refreshOk <= 1'b0;
			windowError <= 1'b0;
			wdResetOut <= 1'b0;
			pulseCnt <= '0;
			armEnable <= 1'b0;
			deployInhibit <= 1'b1;
		end else begin
			status.wdResetFlag <= resetFlag;
			status.testModeFlag <= state == ST_TEST;
			status.armingLockout <= lockout;
			status.disablePinState <= disabled;
			status.thresholdWriteLock <= thLock;
			status.retryCount <= retryCnt;
			status.timerCount <= timer;
			refreshOk <= okEvt & ~machineReset;
			windowError <= anyErr & ~machineReset & ~(state == ST_RESET);
			if (machineReset) begin
				pulseCnt <= '0;
				wdResetOut <= 1'b0;
			end else if (anyErr & ~(state == ST_RESET)) begin
				pulseCnt <= 12'(RST_PULSE_CYC - 1);
				wdResetOut <= 1'b1;
			end else if (pulseCnt != 12'd0)
				pulseCnt <= pulseCnt - 12'd1;
			else
				wdResetOut <= 1'b0;
			armEnable <= ~lockout & ~resetFlag & ((state == ST_RUN) | (state == ST_OVERRIDE)) & ~machineReset;
			deployInhibit <= ~((state == ST_RUN) | (state == ST_OVERRIDE)) | lockout;
		end
	end

	chk_wrong_key_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		(svcWr & ~goodKey & ~expired & ~initTimeout & ~machineReset) |=> !windowError)
		else $error("wrong key raised window error");
	chk_test_flag_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_TEST) |=> status.testModeFlag)
		else $error("test flag missing in test state");
	chk_lockout_arm_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		lockout |=> !armEnable)
		else $error("arming while locked out");
	chk_init_arm_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_INITIAL) |=> !armEnable)
		else $error("arming in initial state");
	chk_test_no_deploy: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_TEST) |=> deployInhibit)
		else $error("deploy allowed in test state");
	chk_disable_no_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
		disabled |=> (timer == TIMER_RST) && !windowError)
		else $error("fault while disabled");
	chk_machine_reset_init: assert property (@(posedge core_clk) disable iff (!rst_n)
		machineReset |=> (state == ST_INITIAL) ##1 !status.armingLockout)
		else $error("machine reset not honoured");
	chk_error_to_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		(anyErr & ~machineReset & (state != ST_RESET)) |=> (state == ST_RESET) && wdResetOut)
		else $error("error did not enter reset state");
	chk_flag_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
		(resetFlag & ~machineReset) |=> resetFlag)
		else $error("reset flag lost");
	chk_thresh_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
		thLock |=> $stable(retryTh))
		else $error("threshold changed after lock");
endmodule
`default_nettype wire

/* hdl/wdg_pkg.sv */
// Package for the windowed SPI watchdog: constants, codes, carriers and state encoding
package wdg_pkg;
	// Service codes in the two-bit service field
	localparam logic [1:0] CODE_A = 2'h1;
	localparam logic [1:0] CODE_B = 2'h2;
	// Core clock rate and derived timing
	localparam int CORE_HZ = 40_000_000;
	localparam int FAST_STEP_NS = 8000;
	localparam int SLOW_STEP_NS = 64000;
	localparam int FAST_SPAN_US = 2000;
	localparam int SLOW_SPAN_US = 16300;
	localparam int FAST_STEP_CYC = FAST_STEP_NS / 25;
	localparam int SLOW_STEP_CYC = SLOW_STEP_NS / 25;
	localparam int FAST_MAX_TICKS = FAST_SPAN_US * 1000 / FAST_STEP_NS;
	localparam int SLOW_MAX_TICKS = SLOW_SPAN_US * 1000 / SLOW_STEP_NS;
	localparam int RST_STATE_MS = 1;
	localparam int RST_STATE_CYC = RST_STATE_MS * (CORE_HZ / 1000);
	localparam int INIT_DEADLINE_MS = 500;
	localparam int INIT_DEADLINE_CYC = INIT_DEADLINE_MS * (CORE_HZ / 1000);
	localparam int RST_PULSE_US = 100;
	localparam int RST_PULSE_CYC = RST_PULSE_US * (CORE_HZ / 1000000);
	// Reset values
	localparam logic [7:0] WIN_MIN_RST = 8'h10;
	localparam logic [7:0] WIN_DELTA_RST = 8'h10;
	localparam logic [3:0] RETRY_TH_RST = 4'h3;
	localparam logic [7:0] TIMER_RST = 8'h00;

	typedef enum logic [4:0] {
		ST_INITIAL = 5'b00001,
		ST_RUN = 5'b00010,
		ST_TEST = 5'b00100,
		ST_RESET = 5'b01000,
		ST_OVERRIDE = 5'b10000
	} wdg_state_t;

	// Host command, one-cycle pulses in the link domain
	typedef struct packed {
		logic serviceWr;
		logic [1:0] serviceCode;
		logic testEntry;
		logic overrideSet;
		logic cfgWr;
		logic slowMode;
		logic [7:0] windowMin;
		logic [7:0] windowDelta;
		logic thWr;
		logic [3:0] retryThreshold;
	} wdg_cmd_t;

	// Status readable by the host
	typedef struct packed {
		logic wdResetFlag;
		logic testModeFlag;
		logic armingLockout;
		logic disablePinState;
		logic thresholdWriteLock;
		logic [3:0] retryCount;
		logic [7:0] timerCount;
	} wdg_stat_t;
endpackage

/* tb/wdg_host.sv */
// Host model: issues one command word at a time on the link clock
`timescale 1ns/1ps
`default_nettype none
module wdg_host import wdg_pkg::*; (
	// Link side
	input wire logic linkClk,
	output wdg_cmd_t linkCmd
);
	initial linkCmd = '0;

	// Strobe for one link cycle, then leave data fields scrambled
	task automatic send(input wdg_cmd_t c);
		wdg_cmd_t r;
		r = ~c;
		r.serviceWr = 1'b0;
		r.testEntry = 1'b0;
		r.overrideSet = 1'b0;
		r.cfgWr = 1'b0;
		r.thWr = 1'b0;
		@(posedge linkClk);
		linkCmd <= c;
		@(posedge linkClk);
		linkCmd <= r;
		// Spacing between commands
		repeat (8) @(posedge linkClk);
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module testbench import wdg_pkg::*;;
	logic core_clk = 0, rst_n = 0, linkClk = 0, machineReset = 0, initOpState = 1, disablePin = 0;
	wdg_cmd_t linkCmd;
	wdg_stat_t status;
	logic refreshOk, windowError, wdResetOut, armEnable, deployInhibit, seen;
	int errors = 0, n_tests = 0;

	wdg_host u_host (.linkClk(linkClk), .linkCmd(linkCmd));
	wdg_watchdog #(.RST_STATE_CYCLES(50), .INIT_DEADLINE_CYCLES(2000)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .linkClk(linkClk), .machineReset(machineReset),
		.linkCmd(linkCmd), .initOpState(initOpState), .disablePin(disablePin), .status(status),
		.refreshOk(refreshOk), .windowError(windowError), .wdResetOut(wdResetOut),
		.armEnable(armEnable), .deployInhibit(deployInhibit));

	initial forever #12.5 core_clk = ~core_clk;
	initial begin
		#3;
		forever #7.5 linkClk = ~linkClk;
	end

	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Watch for a pulse: which=1 refresh, which=0 error
	task automatic waitp(input int n, input bit which, output logic s);
		s = 0;
		repeat (n) begin
			@(negedge core_clk);
			if ((which ? refreshOk : windowError) === 1'b1)
				s = 1;
		end
	endtask

	task automatic cmd(input int kind, input logic [7:0] v);
		wdg_cmd_t c;
		c = '0;
		c.serviceCode = v[1:0];
		c.retryThreshold = v[3:0];
		c.windowMin = v;
		c.windowDelta = 8'h08;
		c.serviceWr = (kind == 0);
		c.testEntry = (kind == 1);
		c.thWr = (kind == 2);
		c.cfgWr = (kind == 3);
		c.overrideSet = (kind == 4);
		u_host.send(c);
	endtask

	task automatic mreset();
		machineReset = 1;
		cyc(2);
		machineReset = 0;
		cyc(4);
		check("armEnable", armEnable, 0);
		check("lockWr", status.thresholdWriteLock, 0);
	endtask

	task automatic t_reset();
		check("deployInhibit", deployInhibit, 1);
		check("armEnable", armEnable, 0);
		check("flags", {status.wdResetFlag, status.armingLockout, status.retryCount}, 0);
	endtask

	task automatic t_pin();
		disablePin = 1;
		cyc(4);
		check("pinState", status.disablePinState, 1);
		cmd(1, 8'h00);
		cyc(4);
		check("override arm", armEnable, 1);
		waitp(2200, 0, seen);
		check("no fault", seen, 0);
		disablePin = 0;
		cyc(4);
		check("pinState", status.disablePinState, 0);
		mreset();
	endtask

	task automatic t_deadline();
		waitp(2200, 0, seen);
		check("deadline err", seen, 1);
		cyc(2);
		check("rstOut", wdResetOut, 1);
		check("rstFlag", status.wdResetFlag, 1);
		cyc(150);
		check("kept", {status.wdResetFlag, status.retryCount}, {1'b1, 4'h1});
		check("armEnable", armEnable, 0);
		mreset();
		cmd(4, 8'h00);
		waitp(2200, 0, seen);
		check("override quiet", seen, 0);
		mreset();
	endtask

	task automatic t_run();
		cmd(3, 8'h04);
		initOpState = 0;
		cmd(2, 8'h02);
		cmd(0, CODE_A);
		cyc(4);
		check("lockWr", status.thresholdWriteLock, 1);
		cmd(2, 8'h0F);
		cmd(3, 8'h00);
		cmd(0, 8'h00);
		cmd(0, 8'h03);
		waitp(400, 0, seen);
		check("wrong key", seen, 0);
		cyc(1700);
		check("timer runs", status.timerCount != 8'h00, 1);
		fork
			cmd(0, CODE_B);
			waitp(200, 1, seen);
		join
		check("refresh", seen, 1);
		check("timer cleared", status.timerCount, 8'h00);
		cyc(1700);
		cmd(0, CODE_B);
		fork
			cmd(0, CODE_A);
			waitp(200, 1, seen);
		join
		check("refresh BA", seen, 1);
		cmd(1, 8'h00);
		cyc(4);
		check("testFlag", status.testModeFlag, 1);
		check("inhibit", deployInhibit, 1);
		mreset();
		check("testFlag", status.testModeFlag, 0);
	endtask

	task automatic t_lock();
		cmd(2, 8'h02);
		for (int i = 1; i <= 2; i++) begin
			cmd(0, CODE_A);
			fork
				cmd(0, CODE_A);
				waitp(200, 0, seen);
			join
			check("early err", seen, 1);
			cyc(150);
			check("lockout", status.armingLockout, i == 2);
		end
		check("retries", status.retryCount, 4'h2);
		check("armEnable", armEnable, 0);
	endtask

	initial begin
		cyc(4);
		rst_n = 1;
		cyc(2);
		t_reset();
		t_pin();
		t_deadline();
		t_run();
		t_lock();
		stop_test();
	end

	initial begin
		#1_000_000;
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
